//--- hsps_status.sv
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "hsps_consts.svh"

// How it works
// - Bits 9:8 show buffer fill: 0 empty, 2 partial, 3 full.
// - In transmit, a system write into a full buffer sets bit 4.
// - In receive, a system read from an empty buffer sets bit 4.
// - Bit 4 stays set until software writes one to it.
// - Bit 3 reads zero when transmit is full or receive is empty.
// - Bit 3 reads one when transmit has room or receive has data.
// - Frame sync errors and buffer over or underflow are both reported.
// - Bit 2 flags a sync inside a frame or a short late sync.
// - Bit 1 flags serial underflow or overflow; cleared by writing one.

module hsps_status
  import hsps_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  // System side buffer traffic.
  input  wire logic        sys_wr_word,
  input  wire logic        sys_rd_word,
  // Serial side.
  input  wire logic        fs_pin,
  input  wire logic        bit_tick,
  // Interrupt.
  output var  logic        irq
);

  hsps_regs_t r;
  hsps_regs_t next_r;
  logic       fs_err_pulse;
  logic       word_done;
  logic       wr_stat;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       sys_ovf;
  logic       sys_unf;
  logic       ser_unf;
  logic       ser_ovf;
  logic       push;
  logic       pop;

  // Maps the buffer level to its fill encoding.
  function automatic logic [1:0] fill_code(input logic [1:0] lvl);
    logic [1:0] code;
    code = `HSPS_FILL_PART;
    if (lvl == 2'h0) begin
      code = `HSPS_FILL_EMPTY;
    end else if (lvl == `HSPS_DEPTH) begin
      code = `HSPS_FILL_FULL;
    end
    return code;
  endfunction

  // Bit 3: room to write in transmit, data to read in receive.
  function automatic logic data_flag(input logic d, input logic [1:0] lvl);
    return d ? (lvl != `HSPS_DEPTH) : (lvl != 2'h0);
  endfunction

  // Frame bit counting and sync checks.
  hsps_fs_check u_fs_check (
    .clk       (clk),
    .reset_n   (reset_n),
    .fs        (r.fs_level),
    .bit_tick  (bit_tick),
    .word_len  (r.word_len),
    .late_fs   (r.late_fs),
    .fs_err    (fs_err_pulse),
    .word_done (word_done)
  );

  // Register decode.
  assign wr_stat = wr && (addr == `HSPS_OFS_STATUS);
  assign wr_ctrl = wr && (addr == `HSPS_OFS_CTRL);
  assign wr_mask = wr && (addr == `HSPS_OFS_MASK);

  // Error events of both sides, chosen by direction.
  assign sys_ovf = r.dir && sys_wr_word && (r.level == `HSPS_DEPTH);
  assign sys_unf = !r.dir && sys_rd_word && (r.level == 2'h0);
  assign ser_unf = r.dir && word_done && (r.level == 2'h0);
  assign ser_ovf = !r.dir && word_done && (r.level == `HSPS_DEPTH);

  // Accepted buffer moves; an erroring move does not change the level.
  assign push = r.dir ? (sys_wr_word && !sys_ovf) : (word_done && !ser_ovf);
  assign pop  = r.dir ? (word_done && !ser_unf) : (sys_rd_word && !sys_unf);

  // Next state of the whole block.
  always_comb begin
    next_r = r;

    // Three stage pin sync; a change counts once stages two and three agree.
    next_r.fs_pipe = {r.fs_pipe[1:0], fs_pin};
    if (r.fs_pipe[1] == r.fs_pipe[2]) begin
      next_r.fs_level = r.fs_pipe[2];
    end

    // Live buffer level, never touched by register writes.
    next_r.level = r.level + {1'b0, push} - {1'b0, pop};

    // Sticky flags: a set in the same cycle as a clear wins.
    next_r.sys_err = (r.sys_err && !(wr_stat && wdata[`HSPS_BIT_SYSERR]))
                     || sys_ovf || sys_unf;
    next_r.fs_err = (r.fs_err && !(wr_stat && wdata[`HSPS_BIT_FRAME_SYNC_ERROR]))
                    || fs_err_pulse;
    next_r.ser_err = (r.ser_err && !(wr_stat && wdata[`HSPS_BIT_SERERR]))
                     || ser_unf || ser_ovf;

    // Control and mask registers.
    if (wr_ctrl) begin
      next_r.dir = wdata[`HSPS_BIT_DIR];
      next_r.late_fs = wdata[`HSPS_BIT_LATEFS];
      next_r.word_len = wdata[`HSPS_WLEN_LSB +: 5];
    end
    if (wr_mask) begin
      next_r.mask = {wdata[`HSPS_BIT_SYSERR], wdata[`HSPS_BIT_FRAME_SYNC_ERROR],
                     wdata[`HSPS_BIT_SERERR]};
    end

    // Read data stands only in the cycle after the read strobe.
    next_r.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `HSPS_OFS_STATUS: begin
          next_r.rdata[`HSPS_FILL_LSB +: 2] = fill_code(r.level);
          next_r.rdata[`HSPS_BIT_SYSERR] = r.sys_err;
          next_r.rdata[`HSPS_BIT_DATA] = data_flag(r.dir, r.level);
          next_r.rdata[`HSPS_BIT_FRAME_SYNC_ERROR] = r.fs_err;
          next_r.rdata[`HSPS_BIT_SERERR] = r.ser_err;
        end
        `HSPS_OFS_CTRL: begin
          next_r.rdata[`HSPS_BIT_DIR] = r.dir;
          next_r.rdata[`HSPS_BIT_LATEFS] = r.late_fs;
          next_r.rdata[`HSPS_WLEN_LSB +: 5] = r.word_len;
        end
        `HSPS_OFS_MASK: begin
          next_r.rdata[`HSPS_BIT_SYSERR] = r.mask[2];
          next_r.rdata[`HSPS_BIT_FRAME_SYNC_ERROR] = r.mask[1];
          next_r.rdata[`HSPS_BIT_SERERR] = r.mask[0];
        end
        default: begin
          next_r.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Level interrupt from the unmasked sticky flags.
    next_r.irq = |({next_r.sys_err, next_r.fs_err, next_r.ser_err} & next_r.mask);
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.word_len <= `HSPS_RST_WLEN;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq = r.irq;

  // Checks on the status behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic rd_stat;
  logic quiet;
  assign rd_stat = rd && (addr == `HSPS_OFS_STATUS);
  assign quiet = !sys_wr_word && !sys_rd_word && !word_done;

  fill_code_a: assert property (
    rd_stat |=> (rdata[9:8] == (($past(r.level) == 2'h0) ? 2'h0 :
                 ($past(r.level) == 2'h2) ? 2'h3 : 2'h2)) && (rdata[9:8] != 2'h1))
    else $error("Fill field does not match the buffer level.");

  tx_overflow_a: assert property (
    (r.dir && sys_wr_word && r.level == 2'h2 && !word_done) |=> r.sys_err ##0 (r.level == 2'h2))
    else $error("Transmit overflow was not flagged.");

  rx_underflow_a: assert property (
    (!r.dir && sys_rd_word && r.level == 2'h0 && !word_done) |=> r.sys_err && (r.level == 2'h0))
    else $error("Receive underflow was not flagged.");

  sys_err_hold_a: assert property (
    (r.sys_err && !(wr_stat && wdata[4])) |=> r.sys_err)
    else $error("System transfer error dropped without a write of one.");

  sys_err_clear_a: assert property (
    (r.sys_err && wr_stat && wdata[4] && quiet) |=> !r.sys_err)
    else $error("System transfer error not cleared by a write of one.");

  flag_low_a: assert property (
    (rd_stat && ((r.dir && r.level == 2'h2) || (!r.dir && r.level == 2'h0)))
    |=> !rdata[3])
    else $error("Buffer flag high while transmit full or receive empty.");

  flag_high_a: assert property (
    (rd_stat && ((r.dir && r.level != 2'h2) || (!r.dir && r.level != 2'h0)))
    |=> rdata[3])
    else $error("Buffer flag low while the buffer can be used.");

  fs_err_set_a: assert property (
    fs_err_pulse |=> r.fs_err ##1 (r.fs_err || $past(wr_stat && wdata[2])))
    else $error("Frame sync error was not latched.");

  ser_err_set_a: assert property (
    (word_done && ((r.dir && r.level == 2'h0) || (!r.dir && r.level == 2'h2)))
    |=> r.ser_err)
    else $error("Serial data error was not latched.");

  ro_write_a: assert property (
    (wr_stat && quiet) |=> $stable(r.level))
    else $error("A status write changed the buffer level.");

  irq_level_a: assert property (
    ((r.sys_err && r.mask[2]) || (r.fs_err && r.mask[1]) || (r.ser_err && r.mask[0]))
    |-> irq || $past(!reset_n))
    else $error("Interrupt low while an unmasked flag is set.");

  irq_low_a: assert property (
    !((r.sys_err && r.mask[2]) || (r.fs_err && r.mask[1]) || (r.ser_err && r.mask[0]))
    |-> !irq)
    else $error("Interrupt high with no unmasked flag set.");

  irq_clear_a: assert property (
    (wr_stat && wdata[4] && wdata[2] && wdata[1] && quiet && !fs_err_pulse)
    |=> !irq)
    else $error("Interrupt still high after all flags were cleared.");

  // Read port checks.
  rdata_idle_a: assert property (
    !rd |=> (rdata == 32'h0000_0000))
    else $error("Read data not zero outside a read answer.");

  unmapped_rd_a: assert property (
    (rd && addr != `HSPS_OFS_STATUS && addr != `HSPS_OFS_CTRL && addr != `HSPS_OFS_MASK)
    |=> (rdata == 32'h0000_0000))
    else $error("Unmapped address read back non-zero.");

  status_zero_a: assert property (
    rd_stat |=> (rdata[31:10] == 22'h00_0000) && (rdata[7:5] == 3'h0) && !rdata[0])
    else $error("Unused status bits read non-zero.");

  ctrl_read_a: assert property (
    (rd && addr == `HSPS_OFS_CTRL)
    |=> (rdata[8:4] == $past(r.word_len)) && (rdata[0] == $past(r.dir)))
    else $error("Control read back does not match the stored fields.");

  // Register write checks.
  ctrl_write_a: assert property (
    wr_ctrl |=> (r.dir == $past(wdata[0])) && (r.word_len == $past(wdata[8:4])))
    else $error("Control write did not land.");

  mask_write_a: assert property (
    wr_mask |=> (r.mask == $past({wdata[4], wdata[2], wdata[1]})))
    else $error("Mask write did not land.");

  // Buffer level checks.
  level_range_a: assert property (
    r.level != 2'h3)
    else $error("Buffer level beyond its depth.");

  tx_push_a: assert property (
    (r.dir && sys_wr_word && r.level != 2'h2 && !word_done)
    |=> (r.level == $past(r.level) + 2'h1))
    else $error("Transmit push did not raise the level.");

  rx_pop_a: assert property (
    (!r.dir && sys_rd_word && r.level != 2'h0 && !word_done)
    |=> (r.level == $past(r.level) - 2'h1))
    else $error("Receive pop did not lower the level.");

  tx_pop_a: assert property (
    (r.dir && word_done && r.level != 2'h0 && !sys_wr_word)
    |=> (r.level == $past(r.level) - 2'h1))
    else $error("Serial send did not lower the level.");

  rx_push_a: assert property (
    (!r.dir && word_done && r.level != 2'h2 && !sys_rd_word)
    |=> (r.level == $past(r.level) + 2'h1))
    else $error("Serial receive did not raise the level.");

  tx_wrong_dir_a: assert property (
    (r.dir && sys_rd_word && !sys_wr_word && !word_done) |=> $stable(r.level))
    else $error("A receive pop moved the transmit level.");

  rx_wrong_dir_a: assert property (
    (!r.dir && sys_wr_word && !sys_rd_word && !word_done) |=> $stable(r.level))
    else $error("A transmit push moved the receive level.");

  // Sticky flag and sync filter checks.
  sys_err_quiet_a: assert property (
    (!r.sys_err && !sys_wr_word && !sys_rd_word) |=> !r.sys_err)
    else $error("System transfer error set with no system transfer.");

  fs_err_hold_a: assert property (
    (r.fs_err && !(wr_stat && wdata[2])) |=> r.fs_err)
    else $error("Frame sync error dropped without a write of one.");

  fs_err_clear_a: assert property (
    (r.fs_err && wr_stat && wdata[2] && !fs_err_pulse) |=> !r.fs_err)
    else $error("Frame sync error not cleared by a write of one.");

  ser_err_hold_a: assert property (
    (r.ser_err && !(wr_stat && wdata[1])) |=> r.ser_err)
    else $error("Serial data error dropped without a write of one.");

  ser_err_clear_a: assert property (
    (r.ser_err && wr_stat && wdata[1] && !word_done) |=> !r.ser_err)
    else $error("Serial data error not cleared by a write of one.");

  rx_overflow_a: assert property (
    (!r.dir && word_done && r.level == 2'h2 && !sys_rd_word)
    |=> r.ser_err && (r.level == 2'h2))
    else $error("Receive overflow was not flagged.");

  tx_underflow_a: assert property (
    (r.dir && word_done && r.level == 2'h0 && !sys_wr_word)
    |=> r.ser_err && (r.level == 2'h0))
    else $error("Transmit underflow was not flagged.");

  sync_filter_a: assert property (
    (r.fs_pipe[1] != r.fs_pipe[2]) |=> $stable(r.fs_level))
    else $error("Sync level moved while its stages disagree.");

  // Main scenarios.
  fill_full_c: cover property (r.level == 2'h0 ##[1:20] r.level == 2'h2);
  rx_ovf_c: cover property (!r.dir && ser_ovf);
  tx_ovf_c: cover property (r.dir && sys_ovf);
  rx_unf_c: cover property (!r.dir && sys_unf);
  fs_err_c: cover property (fs_err_pulse ##[1:10] irq);

endmodule

`default_nettype wire

//--- hsps_consts.svh
`ifndef HSPS_CONSTS_SVH
`define HSPS_CONSTS_SVH

// Register byte offsets.
`define HSPS_OFS_STATUS  8'h00
`define HSPS_OFS_CTRL    8'h04
`define HSPS_OFS_MASK    8'h08

// Status and mask bit positions.
`define HSPS_BIT_SYSERR  4
`define HSPS_BIT_DATA    3
`define HSPS_BIT_FRAME_SYNC_ERROR   2
`define HSPS_BIT_SERERR  1
`define HSPS_FILL_LSB    8

// Control bit positions.
`define HSPS_BIT_DIR     0
`define HSPS_BIT_LATEFS  1
`define HSPS_WLEN_LSB    4

// Buffer fill encodings and depth.
`define HSPS_FILL_EMPTY  2'h0
`define HSPS_FILL_PART   2'h2
`define HSPS_FILL_FULL   2'h3
`define HSPS_DEPTH       2'h2

// Reset values.
`define HSPS_RST_WLEN    5'h0f

`endif

//--- hsps_pkg.sv
package hsps_pkg;

  // Frame checker states.
  typedef enum logic {HSPS_FS_IDLE, HSPS_FS_RUN} hsps_fs_state_t;

  // Frame checker state.
  typedef struct packed {
    hsps_fs_state_t state;
    logic           fs_d;
    logic [5:0]     remain;
    logic [5:0]     fs_len;
    logic           fs_err;
    logic           word_done;
  } hsps_fs_regs_t;

  // Status block state.
  typedef struct packed {
    logic [2:0]  fs_pipe;
    logic        fs_level;
    logic [1:0]  level;
    logic        dir;
    logic        late_fs;
    logic [4:0]  word_len;
    logic        sys_err;
    logic        fs_err;
    logic        ser_err;
    logic [2:0]  mask;
    logic [31:0] rdata;
    logic        irq;
  } hsps_regs_t;

endpackage

//--- hsps_fs_check.sv
`timescale 1ns/1ps
`default_nettype none

module hsps_fs_check
  import hsps_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Serial side.
  input  wire logic       fs,
  input  wire logic       bit_tick,
  // Configuration.
  input  wire logic [4:0] word_len,
  input  wire logic       late_fs,
  // Results.
  output var  logic       fs_err,
  output var  logic       word_done
);

  hsps_fs_regs_t r;
  hsps_fs_regs_t next_r;
  logic [5:0]    bits;

  // Word length in bits is the field plus one.
  assign bits = {1'b0, word_len} + 6'h01;

  // Count bits of the frame and the length of the sync pulse.
  always_comb begin
    next_r = r;
    next_r.fs_d = fs;
    next_r.fs_err = 1'b0;
    next_r.word_done = 1'b0;
    if (fs && bit_tick && r.fs_len != 6'h3f) begin
      next_r.fs_len = r.fs_len + 6'h01;
    end
    if (!fs) begin
      next_r.fs_len = 6'h00;
    end
    case (r.state)
      HSPS_FS_IDLE: begin
        if (fs && !r.fs_d) begin
          next_r.state = HSPS_FS_RUN;
          next_r.remain = bits;
        end
      end
      HSPS_FS_RUN: begin
        if (fs && !r.fs_d && r.remain != 6'h00) begin
          next_r.fs_err = 1'b1; // A sync inside a frame.
          next_r.remain = bits;
        end else if (bit_tick) begin
          next_r.remain = r.remain - 6'h01;
          if (r.remain == 6'h01) begin
            next_r.word_done = 1'b1;
            next_r.state = HSPS_FS_IDLE;
          end
        end
      end
      default: begin
        next_r.state = HSPS_FS_IDLE;
      end
    endcase
    if (late_fs && !fs && r.fs_d && r.fs_len < bits) begin
      next_r.fs_err = 1'b1; // A late sync shorter than a word.
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fs_err = r.fs_err;
  assign word_done = r.word_done;

endmodule

`default_nettype wire

//--- hsps_serial_dev.sv
`timescale 1ns/1ps
`default_nettype none

module hsps_serial_dev (
  // Clock.
  input  wire logic clk,
  // Serial lines toward the port.
  output var  logic fs_pin,
  output var  logic bit_tick
);
  // Both lines rest low between frames.
  initial begin
    fs_pin = 1'b0;
    bit_tick = 1'b0;
  end

  // Sends one frame: sync high, then n bit ticks, each followed by gap idle cycles.
  task automatic frame(input int n, input int gap);
    @(posedge clk);
    fs_pin <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bit_tick <= 1'b1;
      @(posedge clk);
      if (gap > 0) begin
        bit_tick <= 1'b0;
        repeat (gap) @(posedge clk);
      end
    end
    bit_tick <= 1'b0;
    fs_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsps_consts.svh"

module testbench;
  import hsps_pkg::*;
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sys_wr_word;
  logic        sys_rd_word;
  logic        fs_pin;
  logic        bit_tick;
  logic        irq;
  int          err_total;
  int          num_checks;
  int          lvl;
  int          r;
  logic        dir;
  logic        sys;
  logic        fse;
  logic        ser;
  logic [31:0] msk;
  logic [31:0] d;

  hsps_status dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sys_wr_word(sys_wr_word), .sys_rd_word(sys_rd_word),
    .fs_pin(fs_pin), .bit_tick(bit_tick), .irq(irq));
  hsps_serial_dev dev (.clk(clk), .fs_pin(fs_pin), .bit_tick(bit_tick));

  // Clock of 20 ns period.
  always #10 clk = ~clk;

  // Expected status word from the level and flag model.
  function automatic logic [31:0] exp_stat();
    logic [1:0] f;
    f = (lvl == 0) ? `HSPS_FILL_EMPTY : (lvl == 1) ? `HSPS_FILL_PART : `HSPS_FILL_FULL;
    return {22'h0, f, 3'h0, sys, dir ? (lvl != 2) : (lvl != 0), fse, ser, 1'b0};
  endfunction

  // Compares and counts.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // System push or pop, with the model following the active direction only.
  task automatic sys_op(input logic push);
    @(posedge clk);
    if (push) sys_wr_word <= 1'b1;
    else sys_rd_word <= 1'b1;
    @(posedge clk);
    sys_wr_word <= 1'b0;
    sys_rd_word <= 1'b0;
    if (push == dir) begin
      if (lvl == (push ? 2 : 0)) sys = 1'b1;
      else lvl = push ? lvl + 1 : lvl - 1;
    end
  endtask

  // One serial word: transmit pops, receive pushes.
  task automatic serial_word(input int gap);
    dev.frame(4, gap);
    if (lvl == (dir ? 0 : 2)) ser = 1'b1;
    else lvl = dir ? lvl - 1 : lvl + 1;
  endtask

  task automatic check_status();
    rd_reg(`HSPS_OFS_STATUS, d);
    chk(d, exp_stat(), "status");
    chk({31'h0, irq}, {31'h0, |(exp_stat() & msk & 32'h16)}, "irq");
  endtask

  task automatic clear_all();
    wr_reg(`HSPS_OFS_STATUS, 32'h16);
    sys = 1'b0;
    fse = 1'b0;
    ser = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    final_report();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    sys_wr_word = 1'b0;
    sys_rd_word = 1'b0;
    err_total = 0;
    num_checks = 0;
    lvl = 0;
    dir = 1'b0;
    sys = 1'b0;
    fse = 1'b0;
    ser = 1'b0;
    msk = 32'h0;
    void'($urandom(32'h2c33));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    check_status();
    rd_reg(`HSPS_OFS_CTRL, d);
    chk(d, 32'hf0, "control reset");
    rd_reg(8'h0c, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    dir = 1'b1;
    wr_reg(`HSPS_OFS_CTRL, 32'h31);
    msk = 32'h16;
    wr_reg(`HSPS_OFS_MASK, msk);
    check_status();
    repeat (3) sys_op(1'b1);
    check_status();
    wr_reg(`HSPS_OFS_STATUS, 32'h3e8);
    check_status();
    for (int i = 0; i < 24; i++) begin
      r = $urandom_range(2, 0);
      if (r < 2) sys_op(r == 0);
      else begin
        d = $urandom();
        wr_reg(`HSPS_OFS_STATUS, d);
        if (d[4]) sys = 1'b0;
      end
      check_status();
    end
    $display("test transmit buffer done");
    clear_all();
    repeat (3) begin
      serial_word($urandom_range(2, 0));
      check_status();
    end
    $display("test transmit serial done");
    clear_all();
    dir = 1'b0;
    wr_reg(`HSPS_OFS_CTRL, 32'h30);
    sys_op(1'b1);
    sys_op(1'b0);
    check_status();
    clear_all();
    repeat (3) begin
      serial_word($urandom_range(2, 0));
      check_status();
    end
    repeat (3) begin
      sys_op(1'b0);
      check_status();
    end
    $display("test receive done");
    clear_all();
    dev.frame(2, 0);
    fse = 1'b1;
    serial_word(1);
    check_status();
    msk = 32'h0;
    wr_reg(`HSPS_OFS_MASK, msk);
    check_status();
    $display("test frame sync done");
    clear_all();
    wr_reg(`HSPS_OFS_CTRL, 32'h32);
    dev.frame(2, 0);
    fse = 1'b1;
    repeat (4) @(posedge clk);
    check_status();
    $display("test late sync done");
    final_report();
  end
endmodule

`default_nettype wire
